//--- logic/pmon_avg.sv
`include "pmon_map.svh"

module pmon_avg (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clr_in,
    input wire pmon_pkg::field3_t avg_code_in,
    input wire pmon_pkg::field3_t bus_ct_in,
    input wire pmon_pkg::field3_t shunt_ct_in,
    input wire pmon_pkg::word_t shunt_sample_in,
    input wire pmon_pkg::word_t bus_sample_in,
    output pmon_pkg::word_t shunt_res_out,
    output pmon_pkg::word_t bus_res_out,
    output logic upd_out
);
    import pmon_pkg::*;

    localparam logic [13:0] CT_US [8] = '{14'(`CT_US_0), 14'(`CT_US_1), 14'(`CT_US_2), 14'(`CT_US_3),
                                          14'(`CT_US_4), 14'(`CT_US_5), 14'(`CT_US_6), 14'(`CT_US_7)};
    localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};

    conv_phase_t phase_q;
    logic [6:0] div_q;
    logic us_tick;
    logic [13:0] us_q;
    logic [13:0] ct_limit;
    logic conv_end;
    logic [10:0] n_q;
    logic [10:0] n_target;
    logic signed [25:0] sh_acc_q;
    logic [25:0] bus_acc_q;
    logic signed [25:0] sh_sum;
    logic [25:0] bus_sum;
    logic [3:0] shift;

    assign us_tick = (div_q == 7'(`US_CYCLES - 1));
    assign ct_limit = (phase_q == PH_SHUNT) ? CT_US[shunt_ct_in] : CT_US[bus_ct_in];
    assign conv_end = us_tick && (us_q >= ct_limit - 14'h0001); // Shorter new code ends the conversion at the next microsecond tick
    assign shift = AVG_SHIFT[avg_code_in];
    assign n_target = 11'(11'h001 << shift) - 11'h001;
    assign sh_sum = sh_acc_q + 26'(signed'(shunt_sample_in));
    assign bus_sum = bus_acc_q + {11'h000, bus_sample_in[14:0]};

    // Microsecond divider
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q <= 7'h00;
        end else if (clr_in || us_tick) begin
            div_q <= 7'h00;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    // Conversion timer and phase
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            us_q <= 14'h0000;
            phase_q <= PH_SHUNT;
        end else if (clr_in) begin
            us_q <= 14'h0000;
            phase_q <= PH_SHUNT;
        end else if (conv_end) begin
            us_q <= 14'h0000;
            case (phase_q)
                PH_SHUNT: phase_q <= PH_BUS;
                PH_BUS: phase_q <= PH_SHUNT;
                default: phase_q <= PH_SHUNT;
            endcase
        end else if (us_tick) begin
            us_q <= us_q + 14'h0001;
        end
    end

    // Accumulate; publish only when the whole average is done
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sh_acc_q <= 26'h0000000;
            bus_acc_q <= 26'h0000000;
            n_q <= 11'h000;
            shunt_res_out <= `REG_RESET;
            bus_res_out <= `REG_RESET;
            upd_out <= 1'b0;
        end else if (clr_in) begin
            sh_acc_q <= 26'h0000000;
            bus_acc_q <= 26'h0000000;
            n_q <= 11'h000;
            shunt_res_out <= `REG_RESET;
            bus_res_out <= `REG_RESET;
            upd_out <= 1'b0;
        end else begin
            upd_out <= 1'b0;
            if (conv_end && phase_q == PH_SHUNT) begin
                sh_acc_q <= sh_sum;
            end
            if (conv_end && phase_q == PH_BUS) begin
                if (n_q >= n_target) begin
                    shunt_res_out <= 16'(sh_acc_q >>> shift);
                    bus_res_out <= 16'(bus_sum >> shift);
                    upd_out <= 1'b1;
                    sh_acc_q <= 26'h0000000;
                    bus_acc_q <= 26'h0000000;
                    n_q <= 11'h000;
                end else begin
                    bus_acc_q <= bus_sum;
                    n_q <= n_q + 11'h001;
                end
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_avg_publish: assert property (upd_out |-> $past(n_q) >= $past(n_target) && $past(phase_q) == PH_BUS)
        else $error("results updated before averaging finished");
    a_conv_bound: assert property (us_q < 14'(`CT_US_7))
        else $error("conversion timer ran past longest time");
endmodule // pmon_avg

//--- logic/pmon_map.svh
`ifndef PMON_MAP_SVH
`define PMON_MAP_SVH

// Register pointer values
`define PTR_CONFIG 8'h00
`define PTR_SHUNT 8'h01
`define PTR_BUS 8'h02
`define PTR_POWER 8'h03
`define PTR_CURRENT 8'h04
`define PTR_CAL 8'h05
`define PTR_MASK 8'h06
`define PTR_LIMIT 8'h07
`define PTR_MAKER 8'h3E

// Configuration field positions
`define CFG_RST_BIT 15
`define CFG_RSVD_HI 14
`define CFG_RSVD_LO 13
`define CFG_RANGE_BIT 12
`define CFG_AVG_HI 11
`define CFG_AVG_LO 9
`define CFG_BCT_HI 8
`define CFG_BCT_LO 6
`define CFG_SCT_HI 5
`define CFG_SCT_LO 3
`define CFG_MODE_HI 2
`define CFG_MODE_LO 0

// Reset values
`define CFG_RESET 16'h4127
`define CFG_RSVD_VAL 2'h2
`define RANGE_RESET 1'h0
`define AVG_RESET 3'h0
`define BCT_RESET 3'h4
`define SCT_RESET 3'h4
`define MODE_RESET 3'h7
`define REG_RESET 16'h0000
`define GC_RESET_BYTE 8'h06

// Timing: microsecond tick from the 100 MHz clock
`define CLK_PERIOD_NS 10
`define US_NS 1000
`define US_CYCLES (`US_NS / `CLK_PERIOD_NS)

// Conversion times in microseconds, codes 0 to 7
`define CT_US_0 140
`define CT_US_1 204
`define CT_US_2 332
`define CT_US_3 588
`define CT_US_4 1100
`define CT_US_5 2116
`define CT_US_6 4156
`define CT_US_7 8244

`endif

//--- logic/pmon_pkg.sv
package pmon_pkg;
    // Conversion phase, gray along shunt -> bus -> shunt
    typedef enum logic [1:0] {
        PH_SHUNT = 2'h0,
        PH_BUS = 2'h1
    } conv_phase_t;
    typedef logic [2:0] field3_t;
    typedef logic [15:0] word_t;
endpackage

//--- logic/pmon_regs.sv
// Summary of operation
// - Configuration resets to 4127h
// - Config bit 15 resets everything, self-clears
// - Config bits 14:13 read 10b, ignore writes
// - Config bit 12 picks shunt range
// - Bits 11:9 pick averaging count
// - Results update only after full average
// - Bits 8:6 pick bus conversion time
// - Bits 5:3 pick shunt conversion time
// - First write byte sets pointer, next two store
// - Reads use last written pointer, or config after a soft reset
// - Words move high byte first
// - General call 06h soft-resets device
`include "pmon_map.svh"

module pmon_regs #(
    parameter logic [15:0] MAKER_ID = 16'hA5C3 // Arbitrary value
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_start_in,
    input wire logic gc_start_in,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic rd_start_in,
    input wire logic tx_ack_in,
    input wire pmon_pkg::word_t shunt_sample_in,
    input wire pmon_pkg::word_t bus_sample_in,
    output logic [7:0] tx_byte_out,
    output logic shunt_range_select_out,
    output pmon_pkg::field3_t averaging_count_out,
    output logic result_upd_out
);
    import pmon_pkg::*;

    logic [7:0] ptr_q;
    logic [1:0] idx_q;
    logic [7:0] msb_q;
    logic gc_q;
    logic soft_rst_q;
    field3_t bus_conv_time_q;
    field3_t shunt_conv_time_q;
    field3_t mode_q;
    word_t cal_q;
    word_t mask_q;
    word_t limit_q;
    word_t rd_word_q;
    word_t shunt_res;
    word_t bus_voltage_res;
    word_t rd_data;
    word_t cfg_word;
    word_t wdata;
    logic wr_commit;
    logic avg_upd;

    assign wdata = {msb_q, rx_byte_in};
    assign wr_commit = rx_valid_in && idx_q == 2'h2 && !gc_q;
    assign cfg_word = {1'b0, `CFG_RSVD_VAL, shunt_range_select_out, averaging_count_out,
                       bus_conv_time_q, shunt_conv_time_q, mode_q};

    always_comb begin
        case (ptr_q)
            `PTR_CONFIG: rd_data = cfg_word;
            `PTR_SHUNT: rd_data = shunt_res;
            `PTR_BUS: rd_data = {1'b0, bus_voltage_res[14:0]};
            `PTR_CAL: rd_data = cal_q;
            `PTR_MASK: rd_data = mask_q;
            `PTR_LIMIT: rd_data = limit_q;
            `PTR_MAKER: rd_data = MAKER_ID;
            default: rd_data = `REG_RESET;
        endcase
    end

    // Transfer framing: pointer byte, then high and low data bytes
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            idx_q <= 2'h0;
            gc_q <= 1'b0;
            msb_q <= 8'h00;
        end else if (wr_start_in || gc_start_in) begin
            idx_q <= 2'h0;
            gc_q <= gc_start_in;
            msb_q <= 8'h00;
        end else if (rx_valid_in) begin
            if (idx_q == 2'h1) begin
                msb_q <= rx_byte_in;
            end
            if (idx_q != 2'h3) begin
                idx_q <= idx_q + 2'h1;
            end
        end
    end

    // Pointer persists until the next write sets it or a soft reset returns it to config
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ptr_q <= `PTR_CONFIG;
        end else if (soft_rst_q) begin
            ptr_q <= `PTR_CONFIG;
        end else if (rx_valid_in && idx_q == 2'h0 && !gc_q) begin
            ptr_q <= rx_byte_in;
        end
    end

    // Soft reset pulse from config bit 15 or general call
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            soft_rst_q <= 1'b0;
        end else if (soft_rst_q) begin
            soft_rst_q <= 1'b0;
        end else if (wr_commit && ptr_q == `PTR_CONFIG && wdata[`CFG_RST_BIT]) begin
            soft_rst_q <= 1'b1;
        end else if (gc_q && rx_valid_in && idx_q == 2'h0 && rx_byte_in == `GC_RESET_BYTE) begin
            soft_rst_q <= 1'b1;
        end
    end

    // Configuration fields
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            shunt_range_select_out <= `RANGE_RESET;
            averaging_count_out <= `AVG_RESET;
            bus_conv_time_q <= `BCT_RESET;
            shunt_conv_time_q <= `SCT_RESET;
            mode_q <= `MODE_RESET;
        end else if (soft_rst_q) begin
            shunt_range_select_out <= `RANGE_RESET;
            averaging_count_out <= `AVG_RESET;
            bus_conv_time_q <= `BCT_RESET;
            shunt_conv_time_q <= `SCT_RESET;
            mode_q <= `MODE_RESET;
        end else if (wr_commit && ptr_q == `PTR_CONFIG && !wdata[`CFG_RST_BIT]) begin
            shunt_range_select_out <= wdata[`CFG_RANGE_BIT];
            averaging_count_out <= wdata[`CFG_AVG_HI:`CFG_AVG_LO];
            bus_conv_time_q <= wdata[`CFG_BCT_HI:`CFG_BCT_LO];
            shunt_conv_time_q <= wdata[`CFG_SCT_HI:`CFG_SCT_LO];
            mode_q <= wdata[`CFG_MODE_HI:`CFG_MODE_LO];
        end
    end

    // Writable word registers; result and identity words have no write path
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cal_q <= `REG_RESET;
            mask_q <= `REG_RESET;
            limit_q <= `REG_RESET;
        end else if (soft_rst_q) begin
            cal_q <= `REG_RESET;
            mask_q <= `REG_RESET;
            limit_q <= `REG_RESET;
        end else if (wr_commit) begin
            case (ptr_q)
                `PTR_CAL: cal_q <= wdata;
                `PTR_MASK: mask_q <= wdata;
                `PTR_LIMIT: limit_q <= wdata;
                default: cal_q <= cal_q;
            endcase
        end
    end

    // Read word captured at read start, high byte first
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_word_q <= `REG_RESET;
            tx_byte_out <= 8'h00;
        end else if (rd_start_in) begin
            rd_word_q <= rd_data;
            tx_byte_out <= rd_data[15:8];
        end else if (tx_ack_in) begin
            tx_byte_out <= rd_word_q[7:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            result_upd_out <= 1'b0;
        end else begin
            result_upd_out <= avg_upd;
        end
    end

    pmon_avg u_avg (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clr_in(soft_rst_q),
        .avg_code_in(averaging_count_out),
        .bus_ct_in(bus_conv_time_q),
        .shunt_ct_in(shunt_conv_time_q),
        .shunt_sample_in(shunt_sample_in),
        .bus_sample_in(bus_sample_in),
        .shunt_res_out(shunt_res),
        .bus_res_out(bus_voltage_res),
        .upd_out(avg_upd)
    );

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence cfg_reset_req;
        wr_commit && ptr_q == `PTR_CONFIG && wdata[`CFG_RST_BIT];
    endsequence
    sequence reset_then_clear;
        soft_rst_q ##1 (!soft_rst_q && cfg_word == `CFG_RESET);
    endsequence
    sequence read_start;
        rd_start_in ##1 (tx_byte_out == $past(rd_data[15:8]));
    endsequence
    sequence cfg_write;
        wr_commit && ptr_q == `PTR_CONFIG && !wdata[`CFG_RST_BIT] && !soft_rst_q;
    endsequence

    a_soft_reset_seq: assert property (cfg_reset_req |=> reset_then_clear)
        else $error("config reset bit did not reset and self-clear");
    a_cfg_default: assert property (soft_rst_q |=> cfg_word == `CFG_RESET)
        else $error("config not at default after soft reset");
    a_rsvd_bits: assert property (wr_commit && ptr_q == `PTR_CONFIG |=> cfg_word[14:13] == 2'h2)
        else $error("reserved config bits changed");
    a_range_write: assert property (wr_commit && ptr_q == `PTR_CONFIG && !wdata[`CFG_RST_BIT]
                                    |=> shunt_range_select_out == $past(wdata[`CFG_RANGE_BIT]))
        else $error("range bit not stored");
    a_avg_write: assert property (wr_commit && ptr_q == `PTR_CONFIG && !wdata[`CFG_RST_BIT]
                                  |=> averaging_count_out == $past(wdata[11:9]))
        else $error("averaging field not stored");
    a_ptr_load: assert property (rx_valid_in && idx_q == 2'h0 && !gc_q && !wr_start_in && !gc_start_in
                                 && !soft_rst_q |=> ptr_q == $past(rx_byte_in))
        else $error("pointer byte not taken");
    a_ptr_hold: assert property (rd_start_in && !rx_valid_in && !soft_rst_q |=> $stable(ptr_q))
        else $error("pointer moved on read");
    a_byte_order: assert property (read_start ##0 (tx_ack_in && !rd_start_in)
                                   |=> tx_byte_out == $past(rd_word_q[7:0]))
        else $error("read bytes out of order");
    a_gc_reset: assert property (gc_q && rx_valid_in && idx_q == 2'h0 && rx_byte_in == `GC_RESET_BYTE
                                 && !soft_rst_q && !wr_start_in && !gc_start_in |=> soft_rst_q)
        else $error("general call reset ignored");
    a_ro_ignore: assert property (wr_commit && ptr_q == `PTR_SHUNT |=> $stable(cal_q) && $stable(limit_q))
        else $error("write to read-only word changed state");

    // Write path
    a_bct_write: assert property (cfg_write |=> bus_conv_time_q == $past(wdata[`CFG_BCT_HI:`CFG_BCT_LO]))
        else $error("bus conversion time not stored");
    a_sct_write: assert property (cfg_write
                                  |=> shunt_conv_time_q == $past(wdata[`CFG_SCT_HI:`CFG_SCT_LO]))
        else $error("shunt conversion time not stored");
    a_cal_write: assert property (wr_commit && ptr_q == `PTR_CAL && !soft_rst_q
                                  |=> cal_q == $past(wdata))
        else $error("calibration word not stored");
    a_mask_write: assert property (wr_commit && ptr_q == `PTR_MASK && !soft_rst_q
                                   |=> mask_q == $past(wdata))
        else $error("alert mask word not stored");
    a_limit_write: assert property (wr_commit && ptr_q == `PTR_LIMIT && !soft_rst_q
                                    |=> limit_q == $past(wdata))
        else $error("alert threshold word not stored");
    a_msb_capture: assert property (rx_valid_in && idx_q == 2'h1 && !wr_start_in && !gc_start_in
                                    |=> msb_q == $past(rx_byte_in))
        else $error("high byte not held");
    a_idx_start: assert property (wr_start_in || gc_start_in
                                  |=> idx_q == 2'h0 && gc_q == $past(gc_start_in))
        else $error("transfer start not framed");
    a_idx_hold: assert property (idx_q == 2'h3 && !wr_start_in && !gc_start_in
                                 |=> idx_q == 2'h3)
        else $error("byte index left the end state");
    a_extra_bytes: assert property (rx_valid_in && idx_q == 2'h3 && !soft_rst_q
                                    |=> $stable(ptr_q) && $stable(cal_q) && $stable(mask_q) && $stable(limit_q))
        else $error("byte past the word changed state");
    a_maker_ro: assert property (wr_commit && ptr_q == `PTR_MAKER && !soft_rst_q
                                 |=> $stable(cal_q) && $stable(mask_q) && $stable(limit_q) && $stable(cfg_word))
        else $error("write to identity word changed state");
    a_cfg_hold: assert property (!wr_commit && !soft_rst_q |=> $stable(cfg_word))
        else $error("config changed without a write");
    a_words_idle: assert property (!wr_commit && !soft_rst_q
                                   |=> $stable(cal_q) && $stable(mask_q) && $stable(limit_q))
        else $error("word register changed without a write");
    a_soft_words: assert property (soft_rst_q |=> cal_q == `REG_RESET && mask_q == `REG_RESET
                                   && limit_q == `REG_RESET && ptr_q == `PTR_CONFIG)
        else $error("soft reset left a word or pointer set");
    a_gc_ptr_hold: assert property (gc_q && rx_valid_in && !soft_rst_q
                                    |=> $stable(ptr_q))
        else $error("general call byte moved pointer");
    a_gc_other_byte: assert property (gc_q && rx_valid_in && rx_byte_in != `GC_RESET_BYTE && !soft_rst_q
                                      |=> !soft_rst_q)
        else $error("other general call byte reset device");

    // Read path
    a_ptr_idle: assert property (!rx_valid_in && !soft_rst_q |=> $stable(ptr_q))
        else $error("pointer moved without a byte");
    a_read_capture: assert property (rd_start_in |=> rd_word_q == $past(rd_data))
        else $error("read word not captured");
    a_maker_read: assert property (rd_start_in && ptr_q == `PTR_MAKER
                                   |=> tx_byte_out == MAKER_ID[15:8])
        else $error("identity high byte wrong");
    a_shunt_read: assert property (rd_start_in && ptr_q == `PTR_SHUNT
                                   |=> tx_byte_out == $past(shunt_res[15:8]))
        else $error("shunt result high byte wrong");
    a_calc_zero: assert property (rd_start_in && (ptr_q == `PTR_POWER || ptr_q == `PTR_CURRENT)
                                  |=> tx_byte_out == 8'h00)
        else $error("power or current word not zero");
    a_tx_hold: assert property (!rd_start_in && !tx_ack_in |=> $stable(tx_byte_out))
        else $error("transmit byte moved without a request");

    // Results
    a_upd_follow: assert property (avg_upd |=> result_upd_out)
        else $error("update pulse not passed on");
    a_result_hold: assert property ($changed(shunt_res) || $changed(bus_voltage_res)
                                    |-> avg_upd || $past(soft_rst_q))
        else $error("result changed between averages");
endmodule // pmon_regs

//--- tb/pmon_host.sv
module pmon_host (
    input wire logic clk_in,
    input wire logic [7:0] tx_byte_in,
    output logic wr_start_out,
    output logic gc_start_out,
    output logic rx_valid_out,
    output logic [7:0] rx_byte_out,
    output logic rd_start_out,
    output logic tx_ack_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wr_start_out = 1'b0;
        gc_start_out = 1'b0;
        rx_valid_out = 1'b0;
        rx_byte_out = 8'hA5;
        rd_start_out = 1'b0;
        tx_ack_out = 1'b0;
    end

    // One byte per cycle; the strobe stays up between bytes
    task automatic send_byte(input logic [7:0] b);
        rx_byte_out = b;
        rx_valid_out = 1'b1;
        @(negedge clk_in);
    endtask

    // Released byte line shows the inverse of the last byte
    task automatic end_bytes();
        rx_valid_out = 1'b0;
        rx_byte_out = ~rx_byte_out;
    endtask

    // Pointer byte, then up to two data bytes, high byte first
    task automatic write_word(input logic [7:0] ptr, input logic [15:0] w, input int n);
        wr_start_out = 1'b1;
        @(negedge clk_in);
        wr_start_out = 1'b0;
        send_byte(ptr);
        if (n > 0) send_byte(w[15:8]);
        if (n > 1) send_byte(w[7:0]);
        end_bytes();
        repeat (3) @(negedge clk_in);
    endtask

    task automatic gen_call(input logic [7:0] b);
        gc_start_out = 1'b1;
        @(negedge clk_in);
        gc_start_out = 1'b0;
        send_byte(b);
        end_bytes();
        repeat (3) @(negedge clk_in);
    endtask

    // High byte taken first, acknowledge brings the low byte
    task automatic read_word(output logic [15:0] w);
        rd_start_out = 1'b1;
        @(negedge clk_in);
        rd_start_out = 1'b0;
        w[15:8] = tx_byte_in;
        tx_ack_out = 1'b1;
        @(negedge clk_in);
        tx_ack_out = 1'b0;
        w[7:0] = tx_byte_in;
        @(negedge clk_in);
    endtask
endmodule // pmon_host

//--- tb/power_monitor_register_map_tb.sv
`include "pmon_map.svh"

module power_monitor_register_map_tb;
    import pmon_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] ID = 16'h5A3C; // Arbitrary value
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    word_t shunt_sample = 16'h8300;
    word_t bus_sample = 16'h1234;
    logic wr_start, gc_start, rx_valid, rd_start, tx_ack, range_sel, upd;
    logic [7:0] rx_byte, tx_byte;
    field3_t avg_code;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    word_t v;
    logic [7:0] ptrs [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h3E};

    always #5 clk_in = ~clk_in;

    pmon_host host (.clk_in(clk_in), .tx_byte_in(tx_byte), .wr_start_out(wr_start), .gc_start_out(gc_start),
        .rx_valid_out(rx_valid), .rx_byte_out(rx_byte), .rd_start_out(rd_start), .tx_ack_out(tx_ack));

    pmon_regs #(.MAKER_ID(ID)) dut (.clk_in(clk_in), .rst_in(rst_in), .wr_start_in(wr_start),
        .gc_start_in(gc_start), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .rd_start_in(rd_start),
        .tx_ack_in(tx_ack), .shunt_sample_in(shunt_sample), .bus_sample_in(bus_sample),
        .tx_byte_out(tx_byte), .shunt_range_select_out(range_sel), .averaging_count_out(avg_code),
        .result_upd_out(upd));

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input word_t seen, input word_t exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Point at a register, then read it back
    task automatic rd_check(input logic [7:0] ptr, input word_t exp, input string name);
        word_t w;
        host.write_word(ptr, 16'h0000, 0);
        host.read_word(w);
        check(name, w, exp);
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 95000) begin
            n_mismatch++;
            $display("wrong value run length expected finish seen timeout");
            summarize();
        end
    end

    initial begin
        logic [2:0] c;
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);

        rd_check(`PTR_CONFIG, 16'h4127, "config reset");
        for (int i = 0; i < 8; i++) begin
            rd_check(ptrs[i], (i == 7) ? ID : 16'h0000, "register reset");
        end
        check("range reset", 16'(range_sel), 16'h0000);
        check("avg reset", 16'(avg_code), 16'h0000);
        $display("test reset values done");

        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            host.write_word(`PTR_CONFIG, {3'b000, c[0], c, c, c, 3'h7}, 2);
            check("avg field", 16'(avg_code), 16'(c));
            check("range field", 16'(range_sel), 16'(c[0]));
            rd_check(`PTR_CONFIG, {3'b010, c[0], c, c, c, 3'h7}, "config fields");
        end
        $display("test config fields done");

        host.write_word(`PTR_SHUNT, 16'hFFFF, 2);
        rd_check(`PTR_SHUNT, 16'h0000, "read-only result");
        host.write_word(`PTR_MAKER, 16'hFFFF, 2);
        rd_check(`PTR_MAKER, ID, "read-only maker");
        host.write_word(`PTR_CAL, 16'hBEEF, 2);
        rd_check(`PTR_CAL, 16'hBEEF, "calibration");
        host.read_word(v);
        check("pointer kept", v, 16'hBEEF);
        host.write_word(`PTR_CAL, 16'h1200, 1);
        rd_check(`PTR_CAL, 16'hBEEF, "lone high byte");
        host.write_word(`PTR_MASK, 16'h1234, 2);
        rd_check(`PTR_MASK, 16'h1234, "alert mask");
        host.write_word(`PTR_LIMIT, 16'h5678, 2);
        rd_check(`PTR_LIMIT, 16'h5678, "alert limit");
        $display("test access done");

        host.write_word(`PTR_CONFIG, 16'hF000, 2);
        host.read_word(v);
        check("config after soft reset", v, 16'h4127);
        check("range after soft reset", 16'(range_sel), 16'h0000);
        rd_check(`PTR_LIMIT, 16'h0000, "limit after soft reset");
        rd_check(`PTR_CAL, 16'h0000, "cal after soft reset");
        rd_check(`PTR_MASK, 16'h0000, "mask after soft reset");
        $display("test soft reset done");

        host.write_word(`PTR_CAL, 16'hBEEF, 2);
        host.write_word(`PTR_CONFIG, 16'h5E00, 2);
        check("avg before general call", 16'(avg_code), 16'h0007);
        host.gen_call(8'h04);
        host.read_word(v);
        check("pointer after other call", v, 16'h5E00);
        check("avg after other call", 16'(avg_code), 16'h0007);
        host.gen_call(8'h06);
        check("avg after general call", 16'(avg_code), 16'h0000);
        rd_check(`PTR_CAL, 16'h0000, "cal after general call");
        rd_check(`PTR_CONFIG, 16'h4127, "config after general call");
        $display("test general call done");

        host.write_word(`PTR_CONFIG, 16'h4007, 2);
        rd_check(`PTR_SHUNT, 16'h0000, "shunt before average");
        c = 3'h0;
        for (int i = 0; i < 60000 && c == 3'h0; i++) begin
            @(negedge clk_in);
            if (upd === 1'b1) c = 3'h1;
        end
        @(negedge clk_in);
        check("result update seen", 16'(c), 16'h0001);
        rd_check(`PTR_SHUNT, 16'h8300, "shunt result");
        rd_check(`PTR_BUS, 16'h1234, "bus result");
        $display("test conversion done");
        summarize();
    end
endmodule // power_monitor_register_map_tb
